//--- rtl/flash_host_defs.vh
/*
  Constants for the parallel flash host controller: command words, sector
  geometry, bus timing and program-cycle timing.
  Assumes a 40 MHz controller clock (25 ns period).
*/
`ifndef FLASH_HOST_DEFS_VH
`define FLASH_HOST_DEFS_VH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define ADDR_W 16
`define DATA_W 8
`define SECTOR_BYTES 128
`define SECTOR_W 9
`define BYTE_W 7
`define ERASED_BYTE 8'hFF

// ----------------------------------------------------------------------------
// Command sequences (neutral defaults, adjustable)
// ----------------------------------------------------------------------------
`define CMD_ADDR_A 16'h5555
`define CMD_ADDR_B 16'h2AAA
`define CMD_DATA_A 8'hAA
`define CMD_DATA_B 8'h55
`define CMD_PROG 8'hA0
`define CMD_ERASE_SETUP 8'h80
`define CMD_ERASE_ALL 8'h10
`define CMD_ID_ENTER 8'h90
`define CMD_ID_EXIT 8'hF0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_NS 25
// Strobe low time, at least 15 ns filter and then some.
`define STROBE_NS 100
`define STROBE_CYC ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
// Strobe high recovery between loads.
`define RECOV_NS 50
`define RECOV_CYC ((`RECOV_NS + `CLK_NS - 1) / `CLK_NS)
// Read access before sampling the data lines.
`define ACCESS_NS 250
`define ACCESS_CYC ((`ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
// Longest gap between loads: 150 us, rounded down.
`define LOAD_GAP_US 150
`define LOAD_GAP_CYC ((`LOAD_GAP_US * 1000) / `CLK_NS)
// Power-on wait and program cycle limit in ms.
`define PWRUP_MS 20
`define PROG_MAX_MS 20
`define MS_CYC ((1000000) / `CLK_NS)

`endif

//--- rtl/flash_bus_cycle.v
/*
  One bus cycle on the flash pins: a read or a single byte write.
  Assumes the caller holds o_busy low requests only while idle.
*/
`include "flash_host_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module flash_bus_cycle (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Request
  input wire i_start,
  input wire i_write,
  input wire [15:0] i_addr,
  input wire [7:0] i_wdata,
  output wire o_busy,
  output reg o_done,
  output reg [7:0] o_rdata,
  // Flash pins
  output reg [15:0] o_addr_lines,
  output reg o_ce_n,
  output reg o_oe_n,
  output reg o_we_n,
  output reg [7:0] o_data_lines,
  output reg o_data_oe,
  input wire [7:0] i_data_lines
);

  localparam ST_IDLE = 2'b00;
  localparam ST_LOW = 2'b01;
  localparam ST_HIGH = 2'b10;

  // Phase lengths, cut to the counter width on purpose.
  localparam [31:0] WRITE_LEN = `STROBE_CYC;
  localparam [31:0] READ_LEN = `ACCESS_CYC + 2;
  localparam [31:0] RECOV_LEN = `RECOV_CYC;

  reg [1:0] state;
  reg [3:0] cnt;
  reg write;
  reg [7:0] sync1;
  reg [7:0] sync2;

  assign o_busy = (state != ST_IDLE);

  // ----------------------------------------------------------------------------
  // Data line synchroniser
  // ----------------------------------------------------------------------------
  // Two stages before the read data is used.
  always @(posedge i_clk) begin
    sync1 <= i_data_lines;
    sync2 <= sync1;
  end

  // ----------------------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------------------
  // Address and data are set on the same clock edge that drops the strobe and held past its rise,
  // so the later falling edge and earlier rising edge both see stable values.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      write <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 8'h00;
      o_addr_lines <= 16'h0000;
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_data_lines <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (i_start) begin
            write <= i_write;
            o_addr_lines <= i_addr;
            o_data_lines <= i_wdata;
            o_data_oe <= i_write;
            o_ce_n <= 1'b0;
            o_oe_n <= i_write;
            o_we_n <= ~i_write;
            cnt <= i_write ? WRITE_LEN[3:0] : READ_LEN[3:0];
            state <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else begin
            if (!write) begin
              o_rdata <= sync2;
            end
            o_ce_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_we_n <= 1'b1;
            cnt <= RECOV_LEN[3:0];
            state <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else begin
            o_data_oe <= 1'b0;
            o_done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

//--- rtl/flash_host.v
/*
  Host controller for a byte-wide sector flash: reads, sector programming
  with the unlock prefix, chip erase and identification read.
  Assumes a user that loads a full sector of data from its own source.
*/
`include "flash_host_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module flash_host #(
  parameter [15:0] CMD_ADDR_A = `CMD_ADDR_A,
  parameter [15:0] CMD_ADDR_B = `CMD_ADDR_B,
  parameter integer LOAD_GAP_CYC = `LOAD_GAP_CYC,
  parameter integer PWRUP_CYC = `PWRUP_MS * `MS_CYC,
  parameter integer PROG_MAX_CYC = `PROG_MAX_MS * `MS_CYC
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // User command
  input wire i_cmd_valid,
  input wire [2:0] i_cmd_op,
  input wire [15:0] i_cmd_addr,
  output wire o_cmd_ready,
  // Program data request, one byte per request
  output reg o_wr_req,
  output reg [6:0] o_wr_index,
  input wire [7:0] i_wr_data,
  // Result
  output reg o_result_valid,
  output reg [7:0] o_result_data,
  output reg o_result_timeout,
  // Flash pins
  output wire [15:0] o_addr_lines,
  output wire o_ce_n,
  output wire o_oe_n,
  output wire o_we_n,
  output wire [7:0] o_data_lines,
  output wire o_data_oe,
  input wire [7:0] i_data_lines
);

  // User operations.
  localparam OP_READ = 3'h0;
  localparam OP_PROG = 3'h1;
  localparam OP_ERASE = 3'h2;
  localparam OP_ID = 3'h3;
  localparam OP_ID_EXIT = 3'h4; // Internal: leaves identification mode.

  // Sequencer states.
  localparam S_PWRUP = 3'h0;
  localparam S_IDLE = 3'h1;
  localparam S_CMD = 3'h2;
  localparam S_FETCH = 3'h3;
  localparam S_LOAD = 3'h4;
  localparam S_POLL = 3'h5;
  localparam S_READ = 3'h6;
  localparam S_WAIT = 3'h7;

  reg [2:0] state;
  reg [2:0] op;
  reg [15:0] addr;
  reg [2:0] step;
  reg [7:0] last_data;
  reg [7:0] prev_poll;
  reg first_poll;
  reg [31:0] timer;
  reg cyc_start;
  reg cyc_write;
  reg [15:0] cyc_addr;
  reg [7:0] cyc_wdata;
  wire cyc_busy;
  wire cyc_done;
  wire [7:0] cyc_rdata;
  reg [2:0] seq_len;
  reg [15:0] seq_addr;
  reg [7:0] seq_data;

  assign o_cmd_ready = (state == S_IDLE);

  // ----------------------------------------------------------------------------
  // Pin cycle engine
  // ----------------------------------------------------------------------------
  flash_bus_cycle u_cycle (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_start(cyc_start),
    .i_write(cyc_write),
    .i_addr(cyc_addr),
    .i_wdata(cyc_wdata),
    .o_busy(cyc_busy),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_addr_lines(o_addr_lines),
    .o_ce_n(o_ce_n),
    .o_oe_n(o_oe_n),
    .o_we_n(o_we_n),
    .o_data_lines(o_data_lines),
    .o_data_oe(o_data_oe),
    .i_data_lines(i_data_lines)
  );

  // ----------------------------------------------------------------------------
  // Command sequence table
  // ----------------------------------------------------------------------------
  // Unlock prefix, then the op word; erase repeats the prefix after setup.
  always @* begin
    seq_len = 3'h3;
    seq_addr = step[0] ? CMD_ADDR_B : CMD_ADDR_A;
    seq_data = step[0] ? `CMD_DATA_B : `CMD_DATA_A;
    if (op == OP_ERASE) begin
      seq_len = 3'h6;
      seq_addr = (step == 3'h1 || step == 3'h4) ? CMD_ADDR_B : CMD_ADDR_A;
      case (step)
        3'h2: seq_data = `CMD_ERASE_SETUP;
        3'h3: seq_data = `CMD_DATA_A;
        3'h4: seq_data = `CMD_DATA_B;
        3'h5: seq_data = `CMD_ERASE_ALL;
        default: seq_data = step[0] ? `CMD_DATA_B : `CMD_DATA_A;
      endcase
    end else if (step == 3'h2) begin
      seq_addr = CMD_ADDR_A;
      seq_data = (op == OP_PROG) ? `CMD_PROG : (op == OP_ID) ? `CMD_ID_ENTER : `CMD_ID_EXIT;
    end
  end

  // ----------------------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= S_PWRUP;
      op <= 3'h0;
      addr <= 16'h0000;
      step <= 3'h0;
      last_data <= 8'h00;
      prev_poll <= 8'h00;
      first_poll <= 1'b0;
      timer <= 32'h0;
      cyc_start <= 1'b0;
      cyc_write <= 1'b0;
      cyc_addr <= 16'h0000;
      cyc_wdata <= 8'h00;
      o_wr_req <= 1'b0;
      o_wr_index <= 7'h00;
      o_result_valid <= 1'b0;
      o_result_data <= 8'h00;
      o_result_timeout <= 1'b0;
    end else begin
      cyc_start <= 1'b0;
      o_wr_req <= 1'b0;
      o_result_valid <= 1'b0;
      case (state)
        S_PWRUP: begin
          // Hold off all traffic until the device's power-on delay is over.
          if (timer >= PWRUP_CYC - 1) begin
            timer <= 32'h0;
            state <= S_IDLE;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        S_IDLE: begin
          if (i_cmd_valid) begin
            op <= i_cmd_op;
            addr <= i_cmd_addr;
            step <= 3'h0;
            o_wr_index <= 7'h00;
            state <= (i_cmd_op == OP_READ) ? S_READ : S_CMD;
          end
        end
        S_CMD: begin
          if (!cyc_busy && !cyc_start) begin
            if (step == seq_len) begin
              if (op == OP_PROG) begin
                state <= S_FETCH;
              end else if (op == OP_ERASE) begin
                first_poll <= 1'b1;
                timer <= 32'h0;
                state <= S_POLL;
              end else if (op == OP_ID) begin
                // Identification: read maker code at 0, part code at 1.
                addr <= {15'h0000, addr[0]};
                state <= S_READ;
              end else begin
                // Exit is written: report the code read before it.
                o_result_valid <= 1'b1;
                state <= S_IDLE;
              end
            end else begin
              cyc_start <= 1'b1;
              cyc_write <= 1'b1;
              cyc_addr <= seq_addr;
              cyc_wdata <= seq_data;
              step <= step + 3'h1;
            end
          end
        end
        S_FETCH: begin
          // Ask the user for the next byte of the sector.
          o_wr_req <= 1'b1;
          state <= S_LOAD;
        end
        S_LOAD: begin
          if (!cyc_busy && !cyc_start && !o_wr_req) begin
            // Sector bits stay fixed, byte index walks all 128 slots.
            cyc_start <= 1'b1;
            cyc_write <= 1'b1;
            cyc_addr <= {addr[15:7], o_wr_index};
            cyc_wdata <= i_wr_data;
            last_data <= i_wr_data;
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          // Back-to-back loads keep the gap far below the 150 us window.
          if (cyc_done) begin
            if (o_wr_index == 7'h7F) begin
              addr <= {addr[15:7], 7'h7F};
              first_poll <= 1'b1;
              timer <= 32'h0;
              state <= S_POLL;
            end else begin
              o_wr_index <= o_wr_index + 7'h01;
              state <= S_FETCH;
            end
          end
        end
        S_POLL: begin
          timer <= timer + 32'h1;
          if (cyc_done) begin
            prev_poll <= cyc_rdata;
            first_poll <= 1'b0;
            // Done when bit 6 stops toggling and, for a program, bit 7 carries true data.
            if (!first_poll && (cyc_rdata[6] == prev_poll[6]) &&
                (op != OP_PROG || cyc_rdata[7] == last_data[7])) begin
              o_result_valid <= 1'b1;
              o_result_data <= cyc_rdata;
              o_result_timeout <= 1'b0;
              state <= S_IDLE;
            end else if (timer >= PROG_MAX_CYC) begin
              o_result_valid <= 1'b1;
              o_result_data <= cyc_rdata;
              o_result_timeout <= 1'b1;
              state <= S_IDLE;
            end
          end else if (!cyc_busy && !cyc_start) begin
            cyc_start <= 1'b1;
            cyc_write <= 1'b0;
            cyc_addr <= addr;
          end
        end
        S_READ: begin
          if (cyc_done) begin
            o_result_data <= cyc_rdata;
            o_result_timeout <= 1'b0;
            if (op == OP_ID) begin
              // Leave identification mode before reporting.
              op <= OP_ID_EXIT;
              step <= 3'h0;
              state <= S_CMD;
            end else begin
              o_result_valid <= 1'b1;
              state <= S_IDLE;
            end
          end else if (!cyc_busy && !cyc_start) begin
            cyc_start <= 1'b1;
            cyc_write <= 1'b0;
            cyc_addr <= addr;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

//--- tb/flash_host_monitor.sv
/*
  Checker for the flash_host pins and command flow.
  Bound to each flash_host instance; it sees only that module's ports.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_host_monitor #(
  parameter [15:0] CMD_ADDR_A = 16'h5555,
  parameter [15:0] CMD_ADDR_B = 16'h2AAA
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // User side
  input wire logic i_cmd_valid,
  input wire logic [2:0] i_cmd_op,
  input wire logic [15:0] i_cmd_addr,
  input wire logic o_cmd_ready,
  input wire logic o_wr_req,
  input wire logic [6:0] o_wr_index,
  input wire logic [7:0] i_wr_data,
  input wire logic o_result_valid,
  input wire logic [7:0] o_result_data,
  input wire logic o_result_timeout,
  // Flash pins
  input wire logic [15:0] o_addr_lines,
  input wire logic o_ce_n,
  input wire logic o_oe_n,
  input wire logic o_we_n,
  input wire logic [7:0] o_data_lines,
  input wire logic o_data_oe,
  input wire logic [7:0] i_data_lines
);
  // ----------------------------------------------------------------
  // Write strobe counting
  // ----------------------------------------------------------------
  reg prog;
  reg we_q;
  reg [8:0] sec;
  reg [7:0] wr_no;

  // Counts write strobes since the last accepted command.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      prog <= 1'b0;
      we_q <= 1'b1;
      sec <= 9'h000;
      wr_no <= 8'h00;
    end else begin
      we_q <= o_we_n;
      if (o_cmd_ready && i_cmd_valid) begin
        prog <= (i_cmd_op == 3'd1);
        sec <= i_cmd_addr[15:7];
        wr_no <= 8'h00;
      end else if (we_q && !o_we_n) begin
        wr_no <= wr_no + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence take_read;
    o_cmd_ready && i_cmd_valid && i_cmd_op == 3'd0;
  endsequence

  sequence load_fall;
    prog && $fell(o_we_n);
  endsequence

  read_pins_a: assert property (!o_oe_n |-> !o_ce_n && o_we_n && !o_data_oe)
    else $error("read strobe with write strobe or host drive");
  write_pins_a: assert property (!o_we_n |-> !o_ce_n && o_data_oe)
    else $error("write strobe without select or data");
  strobe_width_a: assert property ($fell(o_we_n) |-> (!o_we_n)[*2])
    else $error("write strobe too short");
  latch_stable_a: assert property (!o_we_n && !$past(o_we_n) |-> $stable(o_addr_lines) && $stable(o_data_lines))
    else $error("address or data moved inside a write strobe");
  data_hold_a: assert property ($rose(o_we_n) |-> o_data_oe && $stable(o_data_lines))
    else $error("data released at the strobe rise");
  unlock_order_a: assert property (load_fall |->
    (wr_no != 8'd0 || o_addr_lines == CMD_ADDR_A && o_data_lines == 8'hAA) &&
    (wr_no != 8'd1 || o_addr_lines == CMD_ADDR_B && o_data_lines == 8'h55) &&
    (wr_no != 8'd2 || o_addr_lines == CMD_ADDR_A && o_data_lines == 8'hA0))
    else $error("unlock prefix wrong");
  load_addr_a: assert property (load_fall ##0 wr_no >= 8'd3 |-> o_addr_lines == {sec, wr_no[6:0] - 7'd3})
    else $error("load address out of sector order");
  load_count_a: assert property (prog && o_result_valid |-> wr_no == 8'd131)
    else $error("sector not loaded whole");
  read_answer_a: assert property (take_read |-> ##[4:60] o_result_valid)
    else $error("read gave no result");
endmodule

bind flash_host flash_host_monitor #(.CMD_ADDR_A(CMD_ADDR_A), .CMD_ADDR_B(CMD_ADDR_B)) u_flash_host_monitor (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
  .i_cmd_addr(i_cmd_addr), .o_cmd_ready(o_cmd_ready), .o_wr_req(o_wr_req), .o_wr_index(o_wr_index),
  .i_wr_data(i_wr_data), .o_result_valid(o_result_valid), .o_result_data(o_result_data),
  .o_result_timeout(o_result_timeout), .o_addr_lines(o_addr_lines), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n),
  .o_we_n(o_we_n), .o_data_lines(o_data_lines), .o_data_oe(o_data_oe), .i_data_lines(i_data_lines));
`default_nettype wire

//--- tb/flash_dev_model.sv
/*
  Behavioural model of the byte-wide sector flash.
  Sees the bench's resolved data bus; it has no clock input and times itself with a 100 ns loop.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
  parameter [15:0] ADDR_A = 16'h5555,
  parameter [15:0] ADDR_B = 16'h2AAA,
  parameter [7:0] MAKER = 8'h5A, // Arbitrary value.
  parameter [7:0] PART = 8'hC3, // Arbitrary value.
  parameter real PWRUP_NS = 10000000.0,
  parameter real GAP_NS = 150000.0,
  parameter real PROG_NS = 10000000.0,
  parameter real SLOW_NS = 20000000.0
) (
  // Host pins
  input wire logic [15:0] i_addr_lines,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [7:0] i_data_lines,
  // Stretches the program time
  input wire logic i_slow,
  // Read drive
  output logic [7:0] o_data_lines,
  output logic o_data_en
);
  // ----------------------------------------------------------------
  // Array and control state
  // ----------------------------------------------------------------
  reg [7:0] mem [0:65535];
  reg [7:0] lat [0:127];
  reg [127:0] loaded;
  reg [2:0] step;
  reg [1:0] kind;
  reg loading, busy, idm, tog;
  reg [15:0] wa;
  reg [8:0] sec;
  reg [7:0] d, last_d;
  realtime fall_t, gap_end, busy_end;
  integer i;
  wire wr_n = i_ce_n | i_we_n | ~i_oe_n;
  wire rd_n = i_ce_n | i_oe_n | ~i_we_n;
  wire poll = busy | loading;

  // Drives only in a read; status replaces data while a cycle runs.
  assign o_data_en = ~rd_n;
  assign o_data_lines = poll ? {~last_d[7], tog, last_d[5:0]} :
    idm ? (i_addr_lines[0] ? PART : MAKER) : mem[i_addr_lines];

  task start(input [1:0] k);
    begin
      kind = k;
      busy = 1'b1;
      busy_end = $realtime + (i_slow ? SLOW_NS : PROG_NS);
    end
  endtask

  initial begin
    for (i = 0; i < 65536; i = i + 1) mem[i] = 8'hFF;
    {loading, busy, idm, tog, step, loaded} = 0;
    last_d = 8'hFF;
    fall_t = 0.0;
  end

  // Each read during a cycle flips the toggle bit.
  always @(negedge rd_n) if (poll) tog = ~tog;
  always @(negedge wr_n) begin
    wa = i_addr_lines;
    fall_t = $realtime;
  end

  // Decodes a completed write; short pulses and early writes are dropped.
  always @(posedge wr_n) begin
    d = i_data_lines;
    if ($realtime - fall_t >= 15.0 && $realtime >= PWRUP_NS && !busy) begin
      if (loading) begin
        lat[wa[6:0]] = d;
        loaded[wa[6:0]] = 1'b1;
        sec = wa[15:7];
        last_d = d;
        gap_end = $realtime + GAP_NS;
      end else if (step == 3'd0 && wa == ADDR_A && d == 8'hAA) step = 3'd1;
      else if ((step == 3'd1 || step == 3'd4) && wa == ADDR_B && d == 8'h55) step = step + 3'd1;
      else if (step == 3'd3 && wa == ADDR_A && d == 8'hAA) step = 3'd4;
      else if (step == 3'd2 && wa == ADDR_A && d == 8'h80) step = 3'd3;
      else if (step == 3'd2 && wa == ADDR_A && d == 8'hA0) begin
        {step, loaded} = 0;
        loading = 1'b1;
        gap_end = $realtime + GAP_NS;
      end else if (step == 3'd2 && wa == ADDR_A && (d == 8'h90 || d == 8'hF0)) begin
        step = 3'd0;
        idm = (d == 8'h90);
      end else begin
        last_d = d;
        start((step == 3'd5 && wa == ADDR_A && d == 8'h10) ? 2'd2 : 2'd0);
        step = 3'd0;
      end
    end
  end

  // Internal oscillator closes the load window and ends the cycle.
  always #100 begin
    if (loading && $realtime >= gap_end) begin
      loading = 1'b0;
      start(2'd1);
    end
    if (busy && $realtime >= busy_end) begin
      if (kind == 2'd1) for (i = 0; i < 128; i = i + 1) mem[{sec, i[6:0]}] = loaded[i] ? lat[i] : 8'hFF;
      if (kind == 2'd2) for (i = 0; i < 65536; i = i + 1) mem[i] = 8'hFF;
      busy = 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_flash_host.sv
/*
  Self-checking bench: flash_host drives the flash model.
  Needs flash_host, flash_dev_model and the bound monitor.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_flash_host;
  localparam integer LIMIT = 40000;
  localparam [7:0] MAKER = 8'h5A; // Arbitrary value.
  localparam [7:0] PART = 8'hC3; // Arbitrary value.
  logic i_clk, i_rst_n, i_cmd_valid, i_slow, to;
  logic [2:0] i_cmd_op;
  logic [15:0] i_cmd_addr;
  logic [7:0] i_wr_data, float_q, res;
  wire ready, wr_req, rvalid, rtimeout, ce_n, oe_n, we_n, hdrv, dev_en;
  wire [6:0] wr_index;
  wire [7:0] rdata, hdata, dev_q, bus;
  wire [15:0] addr;
  integer err_count, checked, cycles, seed, i, s;
  reg [7:0] pat [0:127];
  reg [7:0] shadow [0:65535];

  flash_host #(.PWRUP_CYC(10), .PROG_MAX_CYC(2000)) u_flash_host (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
    .i_cmd_addr(i_cmd_addr), .o_cmd_ready(ready), .o_wr_req(wr_req), .o_wr_index(wr_index),
    .i_wr_data(i_wr_data), .o_result_valid(rvalid), .o_result_data(rdata), .o_result_timeout(rtimeout),
    .o_addr_lines(addr), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_data_lines(hdata),
    .o_data_oe(hdrv), .i_data_lines(bus));
  flash_dev_model #(.MAKER(MAKER), .PART(PART), .PWRUP_NS(100.0), .GAP_NS(5000.0), .PROG_NS(10000.0),
    .SLOW_NS(100000.0)) u_flash_dev_model (.i_addr_lines(addr), .i_ce_n(ce_n), .i_oe_n(oe_n),
    .i_we_n(we_n), .i_data_lines(bus), .i_slow(i_slow), .o_data_lines(dev_q), .o_data_en(dev_en));

  // A released bus shows the inverse of its last driven value.
  assign bus = hdrv ? hdata : dev_en ? dev_q : float_q;
  always @(posedge i_clk) if (hdrv || dev_en) float_q <= ~bus;
  always #12.5 i_clk = ~i_clk;
  // Supplies each requested byte just after the request edge.
  always @(posedge i_clk) #1 if (wr_req === 1'b1) i_wr_data = pat[wr_index];
  // Cuts a hang short.
  always @(posedge i_clk) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      err_count = err_count + 1;
      summarize;
    end
  end

  task check(input [7:0] seen, input [7:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // Issues one command and waits for its result.
  task run(input [2:0] op, input [15:0] a);
    integer n;
    begin
      n = 0;
      while (ready !== 1'b1 && n < 5000) @(posedge i_clk) #1 n = n + 1;
      if (ready !== 1'b1) err_count = err_count + 1;
      i_cmd_valid = 1'b1;
      i_cmd_op = op;
      i_cmd_addr = a;
      @(posedge i_clk) #1 i_cmd_valid = 1'b0;
      n = 0;
      while (rvalid !== 1'b1 && n < 20000) @(posedge i_clk) #1 n = n + 1;
      if (rvalid !== 1'b1) err_count = err_count + 1;
      res = rdata;
      to = rtimeout;
    end
  endtask

  task rd(input [15:0] a);
    begin
      run(3'd0, a);
      check(res, shadow[a]);
    end
  endtask

  // Programs a sector with random bytes and reads corners back.
  task prog(input [8:0] sec);
    begin
      for (i = 0; i < 128; i = i + 1) begin
        pat[i] = $random(seed);
        shadow[{sec, i[6:0]}] = pat[i];
      end
      run(3'd1, {sec, 7'h00});
      check({7'h00, to}, 8'h00);
      for (i = 0; i < 6; i = i + 1) begin
        s = (i < 2) ? i * 127 : $random(seed);
        rd({sec, s[6:0]});
      end
    end
  endtask

  task summarize;
    begin
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  initial begin
    {i_clk, i_rst_n, i_cmd_valid, i_cmd_op, i_cmd_addr, i_wr_data, i_slow, float_q} = 0;
    {err_count, checked, cycles} = 0;
    seed = 92915;
    for (i = 0; i < 65536; i = i + 1) shadow[i] = 8'hFF;
    repeat (5) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    rd(16'h1234);
    prog(9'd0);
    prog(9'd511);
    prog(9'd511);
    s = $random(seed);
    prog(s[8:0]);
    rd(16'h0005);
    run(3'd3, 16'h0000);
    check(res, MAKER);
    run(3'd3, 16'h0001);
    check(res, PART);
    rd(16'hFF81);
    run(3'd2, 16'h0000);
    check({7'h00, to}, 8'h00);
    for (i = 0; i < 65536; i = i + 1) shadow[i] = 8'hFF;
    for (i = 0; i < 4; i = i + 1) begin
      s = $random(seed);
      rd({i[0] ? 9'd511 : 9'd0, s[6:0]});
    end
    i_slow = 1'b1;
    run(3'd1, 16'h0080);
    check({7'h00, to}, 8'h01);
    summarize;
  end
endmodule
`default_nettype wire
